// ---- core/ditu_pkg.sv ----
// Package with register map, field layout, reset values and timing for the discrete trigger unit
package ditu_pkg;
	// Printed offsets are not all multiples of four, so they are register indices
	localparam logic [7:0]  IDX_PENDING     = 8'h10;
	localparam logic [7:0]  IDX_PEND_CLR    = 8'h14;
	localparam logic [7:0]  IDX_WC_EN       = 8'h18;
	localparam logic [7:0]  IDX_WC_THR      = 8'h1a;
	localparam logic [7:0]  IDX_REVISION    = 8'h1c;
	localparam logic [7:0]  IDX_MASK        = 8'h20;
	localparam logic [7:0]  IDX_EDGE_SEL    = 8'h24;
	localparam logic [7:0]  IDX_ANY_EDGE    = 8'h28;
	localparam logic [7:0]  IDX_ROUTING     = 8'h2c;
	localparam logic [7:0]  IDX_CFG_LOW     = 8'h30;
	localparam logic [7:0]  IDX_CFG_HIGH    = 8'h32;
	// Own registers: run control, input values, FIFO word count, FIFO pop
	localparam logic [7:0]  IDX_RUN         = 8'h40;
	localparam logic [7:0]  IDX_INPUTS      = 8'h41;
	localparam logic [7:0]  IDX_FIFO_COUNT  = 8'h42;
	localparam logic [7:0]  IDX_FIFO_DATA   = 8'h43;
	localparam int          ADDR_W          = 10;
	localparam int          LINES           = 8;
	localparam int          WC_W            = 12;
	localparam logic [11:0] WC_THR_RST      = 12'hfff;
	localparam logic [11:0] FIFO_MAX_WORDS  = 12'd4092;
	localparam int          FIFO_DEPTH      = 4096;
	localparam logic [1:0]  ROUTE_NONE      = 2'b00;
	localparam logic [1:0]  ROUTE_IRQ       = 2'b01;
	localparam int          CFG_DIR_BIT     = 0;
	localparam int          CFG_THR_BIT     = 1;
	localparam int          CFG_DEB_BIT     = 2;
	localparam logic [15:0] CFG_RW_MASK     = 16'h7777;
	// Revision value is arbitrary
	localparam logic [15:0] REVISION_DEF    = 16'h0001;
	localparam longint      CLK_HZ          = 250000000;
	localparam longint      DEBOUNCE_MS     = 60;
	localparam int          DEBOUNCE_CYC    = int'((DEBOUNCE_MS * CLK_HZ + 999) / 1000);
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	typedef enum logic [1:0] {DITU_PUSH_INPUTS, DITU_PUSH_ZERO, DITU_PUSH_TLO, DITU_PUSH_THI}
		ditu_push_t;
endpackage : ditu_pkg

// ---- core/ditu_top.sv ----
// Discrete I/O trigger unit: lines, debounce, edge triggers, pending, event FIFO, AXI4-Lite
//
// Behaviour
// - A trigger on input line n sets pending bit n; bits 8-15 read zero.
// - Pending bits stay set until software clears them.
// - Writing 1s to pending clear clears those bits; 0s leave them.
// - Pending bits are zero after reset.
// - Word-count interrupt enable bit 0 gates that interrupt, reset disabled.
// - When enabled, interrupt while FIFO word count is at or above threshold.
// - Threshold is 12 bits read/write, resets to 0fff, upper bits zero.
// - A read-only register reports the logic revision.
// - Only lines set in the monitor mask can trigger.
// - Edge select 0 triggers on rising edge, 1 on falling edge.
// - Any-edge bit 1 triggers on both edges of the line.
// - A trigger appends input values and time tag to the FIFO unless a record is in progress or four words do not fit.
// - Routing 00 not connected, 01 interrupt line, 10 and 11 reserved.
// - Four-bit config nibble per line, lines 0-3 low, 4-7 high, top bit reserved.
// - Nibble bit 0 sets direction: 0 input, 1 open output.
// - Nibble bit 1 selects low or high voltage input threshold.
// - Nibble bit 2 enables debounce; change accepted after 60 ms stable.
// - Config writes are taken only while the module is stopped.
// - Mask, edge select, any-edge and low config reset to zero.
// - Each recorded trigger pushes inputs, zero, time tag low, time tag high.
// - FIFO holds at most 4092 words; its count feeds the threshold compare.
// - The stored time tag is a 32-bit count.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module ditu_top
	import ditu_pkg::*;
#(
	parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	input  wire logic [LINES-1:0]  i_line_in,
	input  wire logic [31:0]       i_time_tag,
	output logic      [LINES-1:0]  o_line_out,
	output logic      [LINES-1:0]  o_line_oe,
	output logic      [LINES-1:0]  o_thr_high,
	output logic                   o_irq,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// Register index of a byte address
	function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[9:2];
	endfunction : idx_of

	// Low 16 bits of a write with byte lanes applied
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	logic [LINES-1:0]   pend_r, pend_nxt;
	logic               wc_en_r, wc_en_nxt;
	logic [WC_W-1:0]    wc_thr_r, wc_thr_nxt;
	logic [LINES-1:0]   mask_r, mask_nxt;
	logic [LINES-1:0]   esel_r, esel_nxt;
	logic [LINES-1:0]   any_r, any_nxt;
	logic [1:0]         route_r, route_nxt;
	logic [15:0]        cfg_lo_r, cfg_lo_nxt;
	logic [15:0]        cfg_hi_r, cfg_hi_nxt;
	logic               run_r, run_nxt;
	logic [LINES-1:0]   out_r, out_nxt;
	logic               aw_hold_r, aw_hold_nxt;
	logic               w_hold_r, w_hold_nxt;
	logic [ADDR_W-1:0]  awaddr_r, awaddr_nxt;
	logic [31:0]        wdata_r, wdata_nxt;
	logic [3:0]         wstrb_r, wstrb_nxt;
	logic               bvalid_r, bvalid_nxt;
	logic [1:0]         bresp_r, bresp_nxt;
	logic               rvalid_r, rvalid_nxt;
	logic [31:0]        rdata_r, rdata_nxt;
	logic [1:0]         rresp_r, rresp_nxt;
	logic               wr_fire;
	logic [ADDR_W-1:0]  wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic               rd_fire;
	logic               pop;

	logic [3:0]         cfg_nib [LINES];
	logic [LINES-1:0]   dir_out;
	logic [LINES-1:0]   deb_en;

	// Nibble per line: low register holds lines 0-3, high register lines 4-7
	always_comb begin
		for (int n = 0; n < LINES; n++) begin
			cfg_nib[n] = (n < 4) ? cfg_lo_r[(n%4)*4 +: 4] : cfg_hi_r[(n%4)*4 +: 4];
			dir_out[n] = cfg_nib[n][CFG_DIR_BIT];
			o_thr_high[n] = cfg_nib[n][CFG_THR_BIT];
			deb_en[n] = cfg_nib[n][CFG_DEB_BIT];
		end
	end

	// Open output: pull low when the output bit is 0, release otherwise
	always_comb begin
		o_line_out = '0;
		for (int n = 0; n < LINES; n++) begin
			o_line_oe[n] = !(dir_out[n] && !out_r[n]);
		end
	end

	// Debounce: a candidate value must hold DEB_CYCLES before it is accepted
	logic [LINES-1:0] filt_r, filt_nxt;
	logic [LINES-1:0] prev_r, prev_nxt;
	logic [31:0]      deb_cnt_r [LINES];
	logic [31:0]      deb_cnt_nxt [LINES];
	logic [LINES-1:0] trig;

	always_comb begin
		filt_nxt = filt_r;
		prev_nxt = filt_r;
		trig     = '0;
		for (int n = 0; n < LINES; n++) begin
			deb_cnt_nxt[n] = 32'h0;
			if (!run_r || dir_out[n]) begin
				// Stopped lines and outputs hold their last input value
				filt_nxt[n] = filt_r[n];
			end else if (!deb_en[n]) begin
				filt_nxt[n] = i_line_in[n];
			end else if (i_line_in[n] != filt_r[n]) begin
				deb_cnt_nxt[n] = deb_cnt_r[n] + 32'h1;
				if (deb_cnt_r[n] + 32'h1 >= 32'(DEB_CYCLES)) begin
					filt_nxt[n] = i_line_in[n];
					deb_cnt_nxt[n] = 32'h0;
				end
			end
			// One-cycle trigger per qualifying edge of the accepted value
			if (mask_r[n] && !dir_out[n] && filt_r[n] != prev_r[n]) begin
				if (any_r[n]) begin
					trig[n] = 1'b1;
				end else begin
					trig[n] = esel_r[n] ? !filt_r[n] : filt_r[n];
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			filt_r <= '0;
			prev_r <= '0;
			for (int n = 0; n < LINES; n++) begin
				deb_cnt_r[n] <= 32'h0;
			end
		end else begin
			filt_r <= filt_nxt;
			prev_r <= prev_nxt;
			deb_cnt_r <= deb_cnt_nxt;
		end
	end

	// Event FIFO: four words per trigger, dropped whole when it cannot fit
	logic [15:0]        fifo_mem [FIFO_DEPTH];
	logic [11:0]        wp_r, wp_nxt, rp_r, rp_nxt;
	logic [WC_W-1:0]    cnt_r, cnt_nxt;
	ditu_push_t         ph_r, ph_nxt;
	logic               busy_r, busy_nxt;
	logic [LINES-1:0]   snap_r, snap_nxt;
	logic [31:0]        tag_r, tag_nxt;
	logic               push;
	logic [15:0]        push_word;
	logic               do_pop;

	always_comb begin
		ph_nxt   = ph_r;
		busy_nxt = busy_r;
		snap_nxt = snap_r;
		tag_nxt  = tag_r;
		push     = 1'b0;
		push_word = 16'h0000;
		// A trigger that lands mid-record is not recorded; its pending bit still sets
		if (!busy_r && |trig && cnt_r <= FIFO_MAX_WORDS - 12'd4) begin
			busy_nxt = 1'b1;
			snap_nxt = filt_r;
			tag_nxt  = i_time_tag;
			ph_nxt   = DITU_PUSH_INPUTS;
		end else if (busy_r) begin
			push = 1'b1;
			case (ph_r)
				DITU_PUSH_INPUTS: begin
					push_word = {8'h00, snap_r};
					ph_nxt = DITU_PUSH_ZERO;
				end
				DITU_PUSH_ZERO: begin
					push_word = 16'h0000;
					ph_nxt = DITU_PUSH_TLO;
				end
				DITU_PUSH_TLO: begin
					push_word = tag_r[15:0];
					ph_nxt = DITU_PUSH_THI;
				end
				DITU_PUSH_THI: begin
					push_word = tag_r[31:16];
					ph_nxt = DITU_PUSH_INPUTS;
					busy_nxt = 1'b0;
				end
				default: begin
					busy_nxt = 1'b0;
				end
			endcase
		end
		do_pop = pop && cnt_r != '0;
		wp_nxt = push ? wp_r + 12'd1 : wp_r;
		rp_nxt = do_pop ? rp_r + 12'd1 : rp_r;
		cnt_nxt = cnt_r + {11'd0, push} - {11'd0, do_pop};
	end

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			fifo_mem[wp_r] <= push_word;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			ph_r <= DITU_PUSH_INPUTS;
			busy_r <= 1'b0;
			snap_r <= '0;
			tag_r <= 32'h0;
			wp_r <= 12'd0;
			rp_r <= 12'd0;
			cnt_r <= '0;
		end else begin
			ph_r <= ph_nxt;
			busy_r <= busy_nxt;
			snap_r <= snap_nxt;
			tag_r <= tag_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Interrupt: routed pending bits or the enabled word-count level
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (route_r == ROUTE_IRQ && |pend_r) || (wc_en_r && cnt_r >= wc_thr_r);
		end
	end

	// AXI write side: address and data taken in either order, answer after both
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
	assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
	assign wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
	assign wr_fire = (aw_hold_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_hold_r || (s_axi_wvalid && s_axi_wready));

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r && !s_axi_bready;
		bresp_nxt   = bresp_r;
		pend_nxt = pend_r;
		wc_en_nxt = wc_en_r;
		wc_thr_nxt = wc_thr_r;
		mask_nxt = mask_r;
		esel_nxt = esel_r;
		any_nxt = any_r;
		route_nxt = route_r;
		cfg_lo_nxt = cfg_lo_r;
		cfg_hi_nxt = cfg_hi_r;
		run_nxt = run_r;
		out_nxt = out_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OKAY;
			case (idx_of(wr_addr))
				IDX_PEND_CLR: begin
					if (wr_strb[0]) begin
						pend_nxt = pend_r & ~wr_data[LINES-1:0];
					end
				end
				IDX_WC_EN: begin
					if (wr_strb[0]) begin
						wc_en_nxt = wr_data[0];
					end
				end
				IDX_WC_THR: begin
					wc_thr_nxt = WC_W'(merge16({4'h0, wc_thr_r}, wr_data, wr_strb));
				end
				IDX_MASK: begin
					if (wr_strb[0]) begin
						mask_nxt = wr_data[LINES-1:0];
					end
				end
				IDX_EDGE_SEL: begin
					if (wr_strb[0]) begin
						esel_nxt = wr_data[LINES-1:0];
					end
				end
				IDX_ANY_EDGE: begin
					if (wr_strb[0]) begin
						any_nxt = wr_data[LINES-1:0];
					end
				end
				IDX_ROUTING: begin
					if (wr_strb[0]) begin
						route_nxt = wr_data[1:0];
					end
				end
				IDX_CFG_LOW: begin
					if (!run_r) begin
						cfg_lo_nxt = merge16(cfg_lo_r, wr_data, wr_strb) & CFG_RW_MASK;
					end
				end
				IDX_CFG_HIGH: begin
					if (!run_r) begin
						cfg_hi_nxt = merge16(cfg_hi_r, wr_data, wr_strb) & CFG_RW_MASK;
					end
				end
				IDX_RUN: begin
					if (wr_strb[0]) begin
						run_nxt = wr_data[0];
					end
				end
				IDX_INPUTS: begin
					// Output values change only while running
					if (wr_strb[0] && run_r) begin
						out_nxt = wr_data[LINES-1:0];
					end
				end
				IDX_PENDING, IDX_REVISION, IDX_FIFO_COUNT, IDX_FIFO_DATA: begin
					bresp_nxt = RESP_OKAY;
				end
				default: begin
					bresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		// Trigger set wins over a clear in the same cycle
		pend_nxt = pend_nxt | trig;
	end

	// AXI read side: one-cycle answer, FIFO data read pops the oldest word
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign pop = rd_fire && idx_of(s_axi_araddr) == IDX_FIFO_DATA;

	always_comb begin
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rd_fire) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			case (idx_of(s_axi_araddr))
				IDX_PENDING:    rdata_nxt = {24'h0, pend_r};
				IDX_PEND_CLR:   rdata_nxt = 32'h0;
				IDX_WC_EN:      rdata_nxt = {31'h0, wc_en_r};
				IDX_WC_THR:     rdata_nxt = {20'h0, wc_thr_r};
				IDX_REVISION:   rdata_nxt = {16'h0, REVISION_DEF};
				IDX_MASK:       rdata_nxt = {24'h0, mask_r};
				IDX_EDGE_SEL:   rdata_nxt = {24'h0, esel_r};
				IDX_ANY_EDGE:   rdata_nxt = {24'h0, any_r};
				IDX_ROUTING:    rdata_nxt = {30'h0, route_r};
				IDX_CFG_LOW:    rdata_nxt = {16'h0, cfg_lo_r};
				IDX_CFG_HIGH:   rdata_nxt = {16'h0, cfg_hi_r};
				IDX_RUN:        rdata_nxt = {31'h0, run_r};
				IDX_INPUTS:     rdata_nxt = {24'h0, filt_r};
				IDX_FIFO_COUNT: rdata_nxt = {20'h0, cnt_r};
				IDX_FIFO_DATA:  rdata_nxt = (cnt_r != '0) ? {16'h0, fifo_mem[rp_r]} : 32'h0;
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	// Register state; everything returns to its default on reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			pend_r <= '0;
			wc_en_r <= 1'b0;
			wc_thr_r <= WC_THR_RST;
			mask_r <= '0;
			esel_r <= '0;
			any_r <= '0;
			route_r <= ROUTE_NONE;
			cfg_lo_r <= 16'h0000;
			cfg_hi_r <= 16'h0000;
			run_r <= 1'b0;
			out_r <= '1;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else begin
			pend_r <= pend_nxt;
			wc_en_r <= wc_en_nxt;
			wc_thr_r <= wc_thr_nxt;
			mask_r <= mask_nxt;
			esel_r <= esel_nxt;
			any_r <= any_nxt;
			route_r <= route_nxt;
			cfg_lo_r <= cfg_lo_nxt;
			cfg_hi_r <= cfg_hi_nxt;
			run_r <= run_nxt;
			out_r <= out_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Checks next to the logic they guard
	sequence s_rec_start;
		!busy_r && |trig && cnt_r <= FIFO_MAX_WORDS - 12'd4;
	endsequence
	sequence s_rec_body;
		push [*4] ##1 !push;
	endsequence

	a_pend_set_by_trig: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		trig[0] |=> pend_r[0]) else $error("pending bit not set by trigger");
	a_pend_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		pend_r[1] && !(wr_fire && idx_of(wr_addr) == IDX_PEND_CLR) |=> pend_r[1])
		else $error("pending bit dropped without clear");
	a_pend_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_fire && idx_of(wr_addr) == IDX_PEND_CLR && wr_strb[0] && wr_data[2] && !trig[2]
		|=> !pend_r[2]) else $error("pending clear ignored");
	a_pend_reset: assert property (@(posedge i_ref_clk)
		!i_rstn |=> pend_r == '0) else $error("pending not zero after reset");
	a_wc_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wc_en_r && cnt_r >= wc_thr_r |=> o_irq) else $error("word count interrupt missing");
	a_unmasked_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!mask_r[3] && !pend_r[3] |=> !pend_r[3]) else $error("unmasked line triggered");
	a_rise_select: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		mask_r[0] && !dir_out[0] && !any_r[0] && !esel_r[0] && filt_r[0] && !prev_r[0]
		|-> trig[0]) else $error("rising edge missed");
	a_record_four: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		s_rec_start |=> s_rec_body) else $error("record not four words");
	a_cfg_locked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		run_r |=> $stable(cfg_lo_r) && $stable(cfg_hi_r)) else $error("config changed while running");
	a_route_none: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		route_r == ROUTE_NONE && !wc_en_r |=> !o_irq) else $error("interrupt without cause");

endmodule : ditu_top

// ---- tb/ditu_line_model.sv ----
// Behavioural model of the external discrete lines with far-side sources and open outputs
`timescale 1ns/1ps
module ditu_line_model
	import ditu_pkg::*;
(
	input  wire logic             i_ref_clk,
	input  wire logic [LINES-1:0] i_oe_n,
	input  wire logic [LINES-1:0] i_out,
	output logic      [LINES-1:0] o_line
);
	logic [LINES-1:0] lvl_r = '0;

	// Far-side source changes a line just after a clock edge
	task automatic set_lvl(input int n, input logic v);
		@(posedge i_ref_clk);
		lvl_r[n] <= v;
	endtask : set_lvl

	// A driving open output can only pull low; a released line shows the far-side level
	always_comb begin
		for (int k = 0; k < LINES; k++) begin
			o_line[k] = i_oe_n[k] ? lvl_r[k] : (lvl_r[k] & i_out[k]);
		end
	end
endmodule : ditu_line_model

// ---- tb/ditu_top_tb.sv ----
// Self-checking testbench for the discrete trigger unit
`timescale 1ns/1ps
module ditu_top_tb
	import ditu_pkg::*;
;
	typedef struct packed {
		logic [7:0]  idx;
		logic        wr;
		logic [15:0] wd;
		logic [15:0] ex;
		logic [1:0]  rs;
	} ditu_row_t;
	// Reset reads first, then write and read-back rows
	localparam ditu_row_t ROWS [15] = '{
		'{IDX_PENDING, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{IDX_WC_EN, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{IDX_WC_THR, 1'b0, 16'h0, 16'h0fff, RESP_OKAY},
		'{IDX_REVISION, 1'b0, 16'h0, REVISION_DEF, RESP_OKAY},
		'{IDX_MASK, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{IDX_EDGE_SEL, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{IDX_ANY_EDGE, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{IDX_CFG_LOW, 1'b0, 16'h0, 16'h0000, RESP_OKAY},
		'{8'h50, 1'b0, 16'h0, 16'h0000, RESP_SLVERR},
		'{IDX_WC_THR, 1'b1, 16'hf008, 16'h0008, RESP_OKAY},
		'{IDX_MASK, 1'b1, 16'h0027, 16'h0027, RESP_OKAY},
		'{IDX_EDGE_SEL, 1'b1, 16'h0002, 16'h0002, RESP_OKAY},
		'{IDX_ANY_EDGE, 1'b1, 16'h0004, 16'h0004, RESP_OKAY},
		'{IDX_CFG_LOW, 1'b1, 16'h8882, 16'h0002, RESP_OKAY},
		'{IDX_CFG_HIGH, 1'b1, 16'h1042, 16'h1042, RESP_OKAY}
	};
	logic              i_ref_clk = 1'b0;
	logic              i_rstn = 1'b0;
	logic [LINES-1:0]  line_w;
	logic [31:0]       i_time_tag = 32'h1234abcd;
	logic [LINES-1:0]  o_line_out;
	logic [LINES-1:0]  o_line_oe;
	logic [LINES-1:0]  o_thr_high;
	logic              o_irq;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata = '0;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready = 1'b0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready = 1'b0;
	int                num_errors = 0;
	int                total_checks = 0;
	logic [1:0]        rsp;
	logic [31:0]       rd;

	// 250 MHz reference clock
	always #2 i_ref_clk = ~i_ref_clk;

	// Short debounce count keeps the run brief
	ditu_top #(.DEB_CYCLES(8)) u_dut (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_line_in(line_w), .i_time_tag(i_time_tag),
		.o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_thr_high(o_thr_high), .o_irq(o_irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	ditu_line_model u_lines (.i_ref_clk(i_ref_clk), .i_oe_n(o_line_oe), .i_out(o_line_out),
		.o_line(line_w));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	// Write and data offered together, each dropped once taken, response awaited
	task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] r);
		@(posedge i_ref_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge i_ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_ref_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge i_ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] exp);
		axi_rd(idx, rd, rsp);
		check(name, rd, {16'h0, exp});
	endtask : rd_chk

	// Line change, then time for sync, edge, pending and FIFO record to settle
	task automatic drive(input int n, input logic v);
		u_lines.set_lvl(n, v);
		repeat (12) @(posedge i_ref_clk);
	endtask : drive

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (40000) @(posedge i_ref_clk);
		num_errors++;
		stop_test();
	end

	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		foreach (ROWS[k]) begin
			if (ROWS[k].wr) axi_wr(ROWS[k].idx, ROWS[k].wd, rsp);
			axi_rd(ROWS[k].idx, rd, rsp);
			check("reg_row", rd, {16'h0, ROWS[k].ex});
			check("resp_row", {30'h0, rsp}, {30'h0, ROWS[k].rs});
		end
		$display("register rows done");
		// Start the module, pull output line 7 low
		axi_wr(IDX_RUN, 16'h0001, rsp);
		axi_wr(IDX_INPUTS, 16'h007f, rsp);
		@(posedge i_ref_clk);
		check("thr_high", o_thr_high, 8'h11);
		check("line_oe", o_line_oe, 8'h7f);
		check("line_out", o_line_out, 8'h00);
		// Config write while running must be ignored
		axi_wr(IDX_CFG_LOW, 16'h0000, rsp);
		check("cfg_resp", rsp, RESP_OKAY);
		rd_chk("cfg_locked", IDX_CFG_LOW, 16'h0002);
		$display("config test done");
		// Rising edge on line 0 makes one four-word record
		drive(0, 1'b1);
		rd_chk("pend_rise", IDX_PENDING, 16'h0001);
		rd_chk("fifo_cnt", IDX_FIFO_COUNT, 16'h0004);
		rd_chk("fifo_in", IDX_FIFO_DATA, 16'h0001);
		rd_chk("fifo_zero", IDX_FIFO_DATA, 16'h0000);
		rd_chk("fifo_tlo", IDX_FIFO_DATA, 16'habcd);
		rd_chk("fifo_thi", IDX_FIFO_DATA, 16'h1234);
		rd_chk("inputs_rd", IDX_INPUTS, 16'h0001);
		// Unmasked line and wrong edge give nothing; falling and any-edge do
		drive(3, 1'b1);
		drive(1, 1'b1);
		rd_chk("pend_mask", IDX_PENDING, 16'h0001);
		drive(1, 1'b0);
		drive(2, 1'b1);
		rd_chk("pend_edges", IDX_PENDING, 16'h0007);
		check("irq_route0", o_irq, 1'b0);
		axi_wr(IDX_PEND_CLR, 16'h0005, rsp);
		repeat (20) @(posedge i_ref_clk);
		rd_chk("pend_clr", IDX_PENDING, 16'h0002);
		// Reserved routing code must not reach the interrupt line
		axi_wr(IDX_ROUTING, 16'h0002, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("irq_route2", o_irq, 1'b0);
		axi_wr(IDX_ROUTING, 16'h0001, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("irq_route1", o_irq, 1'b1);
		axi_wr(IDX_PEND_CLR, 16'h0002, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("irq_clear", o_irq, 1'b0);
		$display("trigger test done");
		// Debounced line 5: a short pulse is dropped, a long level is taken
		u_lines.set_lvl(5, 1'b1);
		repeat (3) @(posedge i_ref_clk);
		drive(5, 1'b0);
		rd_chk("deb_pulse", IDX_PENDING, 16'h0000);
		drive(5, 1'b1);
		rd_chk("deb_level", IDX_PENDING, 16'h0020);
		axi_wr(IDX_PEND_CLR, 16'h0020, rsp);
		$display("debounce test done");
		// Three records stored: 12 words against the threshold
		rd_chk("fifo_cnt12", IDX_FIFO_COUNT, 16'h000c);
		axi_wr(IDX_WC_THR, 16'h000c, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("wc_disabled", o_irq, 1'b0);
		axi_wr(IDX_WC_EN, 16'h0001, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("wc_equal", o_irq, 1'b1);
		axi_wr(IDX_WC_THR, 16'h000d, rsp);
		repeat (3) @(posedge i_ref_clk);
		check("wc_below", o_irq, 1'b0);
		axi_wr(IDX_WC_THR, 16'h000c, rsp);
		$display("word count test done");
		// Reset in mid-run with the interrupt raised
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		check("irq_reset", o_irq, 1'b0);
		i_rstn <= 1'b1;
		rd_chk("pend_reset", IDX_PENDING, 16'h0000);
		rd_chk("thr_reset", IDX_WC_THR, 16'h0fff);
		rd_chk("mask_reset", IDX_MASK, 16'h0000);
		$display("reset test done");
		stop_test();
	end
endmodule : ditu_top_tb
